// *** rtl/twc_cache_array.sv ***
// tag, valid, recency and data storage of one two-way cache
`timescale 1ns/1ps
module twc_cache_array
(
    input  wire logic             clk_sys_i,
    input  wire logic             rst_i,
    input  wire twc_pkg::twc_idx_t  lk_index_i,
    input  wire twc_pkg::twc_tag_t  lk_tag_i,
    input  wire twc_pkg::twc_widx_t lk_word_i,
    output logic                  lk_hit_o,
    output logic                  lk_way_o,
    output twc_pkg::twc_word_t    lk_data_o,
    output logic                  lk_victim_o,
    input  wire twc_pkg::twc_idx_t  sn_index_i,
    input  wire twc_pkg::twc_tag_t  sn_tag_i,
    input  wire logic             inv_i,
    output logic                  sn_match_o,
    input  wire logic             touch_i,
    input  wire logic             wr_i,
    input  wire logic             wr_two_i,
    input  wire twc_pkg::twc_idx_t  wr_index_i,
    input  wire logic             wr_way_i,
    input  wire twc_pkg::twc_widx_t wr_word_i,
    input  wire twc_pkg::twc_beat_t wr_data_i,
    input  wire logic             done_i,
    input  wire twc_pkg::twc_tag_t  wr_tag_i
);
    import twc_pkg::*;

    twc_tag_t  tag_mem  [NUM_WAYS][NUM_SETS];
    twc_word_t even_mem [2**MEM_AW];
    twc_word_t odd_mem  [2**MEM_AW];
    logic [NUM_WAYS-1:0][NUM_SETS-1:0] valid_q, valid_d;
    logic [NUM_SETS-1:0]               lru_q, lru_d;
    logic [NUM_WAYS-1:0]               lk_hitv, sn_hitv;
    twc_maddr_t                        rd_addr, wr_addr;

    // two blocks per set, compared side by side
    for (genvar w = 0; w < NUM_WAYS; w++) begin : g_way
        assign lk_hitv[w] = valid_q[w][lk_index_i] && (tag_mem[w][lk_index_i] == lk_tag_i);
        assign sn_hitv[w] = valid_q[w][sn_index_i] && (tag_mem[w][sn_index_i] == sn_tag_i);
    end

    assign lk_hit_o    = |lk_hitv;
    assign lk_way_o    = lk_hitv[WAY1];
    assign sn_match_o  = |sn_hitv;
    assign lk_victim_o = lru_q[lk_index_i];

    // even words on the upper half of a 64-bit beat, odd words on the lower half
    assign rd_addr   = {lk_index_i, lk_way_o, lk_word_i[WORD_W-1:1]};
    assign wr_addr   = {wr_index_i, wr_way_i, wr_word_i[WORD_W-1:1]};
    assign lk_data_o = lk_word_i[0] ? odd_mem[rd_addr] : even_mem[rd_addr];

    always_comb begin
        valid_d = valid_q;
        lru_d   = lru_q;
        if (inv_i) begin
            for (int w = 0; w < NUM_WAYS; w++) begin
                if (sn_hitv[w]) begin
                    valid_d[w][sn_index_i] = 1'b0;
                end
            end
        end
        // a completing fill wins over a snoop hit in the same set
        if (done_i) begin
            valid_d[wr_way_i][wr_index_i] = 1'b1;
            lru_d[wr_index_i]             = ~wr_way_i;
        end
        if (touch_i) begin
            lru_d[lk_index_i] = ~lk_way_o;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            valid_q <= '0;
            lru_q   <= '0;
        end else begin
            valid_q <= valid_d;
            lru_q   <= lru_d;
        end
    end

    // storage arrays carry no reset; valid bits guard them
    always_ff @(posedge clk_sys_i) begin
        if (done_i) begin
            tag_mem[wr_way_i][wr_index_i] <= wr_tag_i;
        end
        if (wr_i && (wr_two_i || !wr_word_i[0])) begin
            even_mem[wr_addr] <= wr_data_i[63:32];
        end
        if (wr_i && wr_two_i) begin
            odd_mem[wr_addr] <= wr_data_i[31:0];
        end else if (wr_i && wr_word_i[0]) begin
            odd_mem[wr_addr] <= wr_data_i[63:32];
        end
    end

endmodule : twc_cache_array

// *** rtl/twc_cache_top.sv ***
// instruction and data two-way caches with shared line-fill and snoop port
`timescale 1ns/1ps
module twc_cache_top
(
    input  wire logic               clk_sys_i,
    input  wire logic               rst_i,
    input  wire logic               bus_64bit_i,
    input  wire logic               ic_req_i,
    input  wire twc_pkg::twc_word_t ic_ea_i,
    input  wire twc_pkg::twc_tag_t  ic_pa_tag_i,
    output logic                    ic_valid_o,
    output logic                    ic_hit_o,
    output twc_pkg::twc_word_t      ic_word_o,
    output twc_pkg::twc_byte_t      ic_byte_o,
    output logic                    ic_busy_o,
    input  wire logic               dc_req_i,
    input  wire twc_pkg::twc_word_t dc_ea_i,
    input  wire twc_pkg::twc_tag_t  dc_pa_tag_i,
    output logic                    dc_valid_o,
    output logic                    dc_hit_o,
    output twc_pkg::twc_word_t      dc_word_o,
    output twc_pkg::twc_byte_t      dc_byte_o,
    output logic                    dc_busy_o,
    output logic                    fill_req_o,
    output twc_pkg::twc_word_t      fill_pa_o,
    output logic                    fill_way_select_o,
    output logic                    fill_is_data_o,
    input  wire logic               fill_beat_i,
    input  wire twc_pkg::twc_beat_t fill_data_i,
    input  wire logic               snoop_valid_i,
    input  wire twc_pkg::twc_word_t snoop_pa_i,
    output logic                    snoop_hit_o
);
    import twc_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_FILL = 2'b10
    } twc_st_t;

    // bus width strap arrives from a pin
    logic      w64_s1_q, w64_s2_q;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            w64_s1_q <= 1'b1;
            w64_s2_q <= 1'b1;
        end else begin
            w64_s1_q <= bus_64bit_i;
            w64_s2_q <= w64_s1_q;
        end
    end

    // per-cache request view; index 0 instruction, 1 data
    logic      [NUM_WAYS-1:0] req;
    twc_word_t                ea   [NUM_WAYS];
    twc_tag_t                 ptag [NUM_WAYS];

    assign req[CACHE_INS] = ic_req_i;
    assign req[CACHE_DAT] = dc_req_i;
    assign ea[CACHE_INS]  = ic_ea_i;
    assign ea[CACHE_DAT]  = dc_ea_i;
    assign ptag[CACHE_INS] = ic_pa_tag_i;
    assign ptag[CACHE_DAT] = dc_pa_tag_i;

    // shared fill state
    twc_st_t   st_q, st_d;
    logic      fsel_q, fsel_d;
    logic      fway_q, fway_d;
    logic      freq_q, freq_d;
    twc_idx_t  fidx_q, fidx_d;
    twc_tag_t  ftag_q, ftag_d;
    logic      snhit_q, snhit_d;
    logic      start, seq_active, seq_two, seq_last, seq_blind;
    twc_widx_t seq_word;

    logic      [NUM_WAYS-1:0] miss_q, sn_match;
    twc_idx_t                 midx_q [NUM_WAYS];
    twc_tag_t                 mtag_q [NUM_WAYS];
    logic      [NUM_WAYS-1:0] mvic_q;
    logic      [NUM_WAYS-1:0] val_q, hit_q;
    twc_word_t                word_q [NUM_WAYS];
    twc_byte_t                byte_q [NUM_WAYS];

    twc_fill_seq u_seq (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .start_i   (start),
        .bus64_i   (w64_s2_q),
        .beat_i    (fill_beat_i),
        .active_o  (seq_active),
        .two_o     (seq_two),
        .word_o    (seq_word),
        .last_o    (seq_last),
        .blind_o   (seq_blind)
    );

    for (genvar c = 0; c < NUM_WAYS; c++) begin : g_cache
        logic      lk_hit, lk_way, lk_vic, take, mine;
        twc_word_t lk_data;
        logic      miss_d, mvic_d, val_d, hit_d;
        twc_idx_t  midx_d;
        twc_tag_t  mtag_d;
        twc_word_t word_d;
        twc_byte_t byte_d;

        // requests are ignored while this cache waits for its fill
        assign take = req[c] && !miss_q[c];
        assign mine = seq_active && (fsel_q == 1'(c));

        twc_cache_array u_arr (
            .clk_sys_i   (clk_sys_i),
            .rst_i       (rst_i),
            .lk_index_i  (twc_index(ea[c])),
            .lk_tag_i    (ptag[c]),
            .lk_word_i   (twc_word_of(ea[c])),
            .lk_hit_o    (lk_hit),
            .lk_way_o    (lk_way),
            .lk_data_o   (lk_data),
            .lk_victim_o (lk_vic),
            .sn_index_i  (twc_index(snoop_pa_i)),
            .sn_tag_i    (snoop_pa_i[TAG_LSB +: TAG_W]),
            .inv_i       (snoop_valid_i),
            .sn_match_o  (sn_match[c]),
            .touch_i     (take && lk_hit),
            .wr_i        (mine && fill_beat_i),
            .wr_two_i    (seq_two),
            .wr_index_i  (fidx_q),
            .wr_way_i    (fway_q),
            .wr_word_i   (seq_word),
            .wr_data_i   (fill_data_i),
            .done_i      (mine && seq_last),
            .wr_tag_i    (ftag_q)
        );

        always_comb begin
            miss_d = miss_q[c];
            midx_d = midx_q[c];
            mtag_d = mtag_q[c];
            mvic_d = mvic_q[c];
            val_d  = take;
            hit_d  = take && lk_hit;
            word_d = word_q[c];
            byte_d = byte_q[c];
            if (take) begin
                word_d = lk_data;
                byte_d = twc_sel_byte(lk_data, ea[c][WORD_LSB-1:OFF_LSB]);
                if (!lk_hit) begin
                    miss_d = 1'b1;
                    midx_d = twc_index(ea[c]);
                    mtag_d = ptag[c];
                    mvic_d = lk_vic;
                end
            end
            if (mine && seq_last) begin
                miss_d = 1'b0;
            end
        end

        always_ff @(posedge clk_sys_i) begin
            if (rst_i) begin
                miss_q[c] <= 1'b0;
                midx_q[c] <= '0;
                mtag_q[c] <= '0;
                mvic_q[c] <= WAY0;
                val_q[c]  <= 1'b0;
                hit_q[c]  <= 1'b0;
                word_q[c] <= '0;
                byte_q[c] <= '0;
            end else begin
                miss_q[c] <= miss_d;
                midx_q[c] <= midx_d;
                mtag_q[c] <= mtag_d;
                mvic_q[c] <= mvic_d;
                val_q[c]  <= val_d;
                hit_q[c]  <= hit_d;
                word_q[c] <= word_d;
                byte_q[c] <= byte_d;
            end
        end
    end

    // data side fills take priority over instruction side
    assign start = (st_q == ST_IDLE) && (|miss_q);

    always_comb begin
        logic sel;
        logic line_hit;
        sel      = miss_q[CACHE_DAT] ? CACHE_DAT : CACHE_INS;
        // the loading line answers snoops except inside its blind window
        line_hit = freq_q && (snoop_pa_i[TAG_LSB +: TAG_W] == ftag_q) && (twc_index(snoop_pa_i) == fidx_q);
        st_d     = st_q;
        fsel_d   = fsel_q;
        fway_d   = fway_q;
        fidx_d   = fidx_q;
        ftag_d   = ftag_q;
        freq_d   = freq_q;
        unique case (st_q)
            ST_IDLE: begin
                if (start) begin
                    st_d   = ST_FILL;
                    fsel_d = sel;
                    fway_d = mvic_q[sel];
                    fidx_d = midx_q[sel];
                    ftag_d = mtag_q[sel];
                    freq_d = 1'b1;
                end
            end
            ST_FILL: begin
                if (seq_last) begin
                    st_d   = ST_IDLE;
                    freq_d = 1'b0;
                end
            end
            default: begin
                st_d   = ST_IDLE;
                freq_d = 1'b0;
            end
        endcase
        snhit_d  = snoop_valid_i && ((|sn_match) || (line_hit && !seq_blind));
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            st_q    <= ST_IDLE;
            fsel_q  <= CACHE_INS;
            fway_q  <= WAY0;
            fidx_q  <= '0;
            ftag_q  <= '0;
            freq_q  <= 1'b0;
            snhit_q <= 1'b0;
        end else begin
            st_q    <= st_d;
            fsel_q  <= fsel_d;
            fway_q  <= fway_d;
            fidx_q  <= fidx_d;
            ftag_q  <= ftag_d;
            freq_q  <= freq_d;
            snhit_q <= snhit_d;
        end
    end

    assign ic_valid_o        = val_q[CACHE_INS];
    assign ic_hit_o          = hit_q[CACHE_INS];
    assign ic_word_o         = word_q[CACHE_INS];
    assign ic_byte_o         = byte_q[CACHE_INS];
    assign ic_busy_o         = miss_q[CACHE_INS];
    assign dc_valid_o        = val_q[CACHE_DAT];
    assign dc_hit_o          = hit_q[CACHE_DAT];
    assign dc_word_o         = word_q[CACHE_DAT];
    assign dc_byte_o         = byte_q[CACHE_DAT];
    assign dc_busy_o         = miss_q[CACHE_DAT];
    assign fill_req_o        = freq_q;
    assign fill_pa_o         = {ftag_q, fidx_q, {OFF_W{1'b0}}};
    assign fill_way_select_o = fway_q;
    assign fill_is_data_o    = fsel_q;
    assign snoop_hit_o       = snhit_q;

endmodule : twc_cache_top

// *** rtl/twc_fill_seq.sv ***
// beat counter and snoop-blind window of one line fill
`timescale 1ns/1ps
module twc_fill_seq
(
    input  wire logic               clk_sys_i,
    input  wire logic               rst_i,
    input  wire logic               start_i,
    input  wire logic               bus64_i,
    input  wire logic               beat_i,
    output logic                    active_o,
    output logic                    two_o,
    output twc_pkg::twc_widx_t      word_o,
    output logic                    last_o,
    output logic                    blind_o
);
    import twc_pkg::*;

    typedef enum logic [1:0] {
        SQ_IDLE = 2'b01,
        SQ_RUN  = 2'b10
    } twc_sq_t;

    twc_sq_t  state_q, state_d;
    twc_cnt_t cnt_q, cnt_d;
    logic     w64_q, w64_d;

    assign active_o = (state_q == SQ_RUN);
    assign two_o    = w64_q;
    assign word_o   = w64_q ? {cnt_q[1:0], 1'b0} : cnt_q[WORD_W-1:0];
    assign last_o   = active_o && beat_i && (cnt_q == ((w64_q ? BEATS_64 : BEATS_32) - BEAT_ONE));
    // snooped addresses are not compared against the loading line here
    assign blind_o  = active_o && (w64_q ? (cnt_q == BLIND_64_FIRST)
                                         : (cnt_q >= BLIND_32_FIRST));

    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        w64_d   = w64_q;
        unique case (state_q)
            SQ_IDLE: begin
                if (start_i) begin
                    state_d = SQ_RUN;
                    cnt_d   = BEAT_ZERO;
                    w64_d   = bus64_i;
                end
            end
            SQ_RUN: begin
                if (beat_i) begin
                    cnt_d = cnt_q + BEAT_ONE;
                    if (last_o) begin
                        state_d = SQ_IDLE;
                    end
                end
            end
            default: begin
                state_d = SQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            state_q <= SQ_IDLE;
            cnt_q   <= BEAT_ZERO;
            w64_q   <= 1'b1;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            w64_q   <= w64_d;
        end
    end

endmodule : twc_fill_seq

// *** rtl/twc_pkg.sv ***
// constants, types and address helpers for the two-way cache pair
package twc_pkg;

    localparam int unsigned NUM_WAYS       = 2;
    localparam int unsigned NUM_SETS       = 128;
    localparam int unsigned WORDS_PER_LINE = 8;
    localparam int unsigned CACHE_KBYTES   = 8;
    localparam int unsigned LINE_BYTES     = 32;

    // effective address fields, lsb-0 numbering of big-endian A0..A31
    localparam int unsigned OFF_LSB   = 0;
    localparam int unsigned OFF_W     = 5;
    localparam int unsigned WORD_LSB  = 2;
    localparam int unsigned WORD_W    = 3;
    localparam int unsigned IDX_LSB   = 5;
    localparam int unsigned IDX_W     = 7;
    localparam int unsigned TAG_LSB   = 12;
    localparam int unsigned TAG_W     = 20;
    localparam int unsigned MEM_AW    = 10;
    localparam int unsigned BYTE_W    = 8;

    localparam logic        WAY0      = 1'b0;
    localparam logic        WAY1      = 1'b1;
    localparam logic        CACHE_INS = 1'b0;
    localparam logic        CACHE_DAT = 1'b1;

    // beats per line and first snoop-blind beat count
    localparam logic [3:0]  BEATS_64       = 4'h4;
    localparam logic [3:0]  BEATS_32       = 4'h8;
    localparam logic [3:0]  BLIND_64_FIRST = 4'h3;
    localparam logic [3:0]  BLIND_32_FIRST = 4'h6;
    localparam logic [3:0]  BEAT_ONE       = 4'h1;
    localparam logic [3:0]  BEAT_ZERO      = 4'h0;

    typedef logic [IDX_W-1:0]        twc_idx_t;
    typedef logic [TAG_W-1:0]        twc_tag_t;
    typedef logic [WORD_W-1:0]       twc_widx_t;
    typedef logic [31:0]             twc_word_t;
    typedef logic [63:0]             twc_beat_t;
    typedef logic [BYTE_W-1:0]       twc_byte_t;
    typedef logic [3:0]              twc_cnt_t;
    typedef logic [MEM_AW-1:0]       twc_maddr_t;

    function automatic twc_idx_t twc_index(input twc_word_t a);
        twc_index = a[IDX_LSB +: IDX_W];
    endfunction : twc_index

    function automatic twc_widx_t twc_word_of(input twc_word_t a);
        twc_word_of = a[WORD_LSB +: WORD_W];
    endfunction : twc_word_of

    // big-endian byte lanes: offset 0 is the most significant byte
    function automatic twc_byte_t twc_sel_byte(input twc_word_t w, input logic [1:0] off);
        twc_sel_byte = w[(3 - off) * BYTE_W +: BYTE_W];
    endfunction : twc_sel_byte

endpackage : twc_pkg

// *** test/twc_cache_top_sva.sv ***
// assertion checker for the two-way cache pair
`timescale 1ns/1ps
module twc_cache_chk
(
    input wire logic               clk_sys_i,
    input wire logic               rst_i,
    input wire logic               bus_64bit_i,
    input wire logic               ic_req_i,
    input wire logic               ic_valid_o,
    input wire logic               ic_busy_o,
    input wire logic               dc_req_i,
    input wire logic               dc_valid_o,
    input wire logic               dc_hit_o,
    input wire logic               dc_busy_o,
    input wire logic               fill_req_o,
    input wire twc_pkg::twc_word_t fill_pa_o,
    input wire logic               fill_way_select_o,
    input wire logic               fill_beat_i,
    input wire logic               snoop_valid_i,
    input wire twc_pkg::twc_word_t snoop_pa_i,
    input wire logic               snoop_hit_o
);
    import twc_pkg::*;
    twc_cnt_t beat_cnt_q;
    twc_cnt_t beat_cnt_d;
    logic     at_last;
    logic     line_m;
    logic     blind;

    // beats already taken in the running fill
    always_comb begin
        beat_cnt_d = (rst_i || !fill_req_o) ? BEAT_ZERO : beat_cnt_q + {3'h0, fill_beat_i};
        at_last    = beat_cnt_q == (bus_64bit_i ? BEATS_64 : BEATS_32) - BEAT_ONE;
        line_m     = snoop_pa_i[31:5] == fill_pa_o[31:5];
        blind      = bus_64bit_i ? beat_cnt_q == BLIND_64_FIRST : beat_cnt_q >= BLIND_32_FIRST;
    end

    always_ff @(posedge clk_sys_i) begin
        beat_cnt_q <= beat_cnt_d;
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    sequence s_last_beat;
        fill_req_o && fill_beat_i && at_last;
    endsequence
    // only snoops between beats; a snoop on a beat edge is ambiguous
    sequence s_quiet_snoop;
        snoop_valid_i && fill_req_o && !fill_beat_i && line_m;
    endsequence

    chk_ic_answer: assert property (ic_req_i && !ic_busy_o |=> ic_valid_o)
        else $error("ic lookup not answered");
    chk_dc_answer: assert property (dc_req_i && !dc_busy_o |=> dc_valid_o)
        else $error("dc lookup not answered");
    chk_busy_refuse: assert property (dc_busy_o |=> !dc_valid_o)
        else $error("lookup answered while busy");
    chk_miss_busy: assert property (dc_valid_o && !dc_hit_o |-> dc_busy_o)
        else $error("miss without busy");
    chk_pa_align: assert property (fill_req_o |-> fill_pa_o[4:0] == 5'h00)
        else $error("fill address not line aligned");
    chk_way_stable: assert property (fill_req_o && $past(fill_req_o) |-> $stable(fill_way_select_o) && $stable(fill_pa_o))
        else $error("fill way or address moved");
    chk_fill_end: assert property (s_last_beat |=> !fill_req_o)
        else $error("fill longer than one line");
    chk_fill_hold: assert property (fill_req_o && !(fill_beat_i && at_last) |=> fill_req_o)
        else $error("fill ended early");
    chk_blind_quiet: assert property (s_quiet_snoop ##0 blind |=> !snoop_hit_o)
        else $error("fill line snooped in blind window");
    chk_snoop_seen: assert property (s_quiet_snoop ##0 !blind |=> snoop_hit_o)
        else $error("fill line snoop missed");
    chk_hit_cause: assert property (snoop_hit_o |-> $past(snoop_valid_i))
        else $error("snoop hit without snoop");
endmodule : twc_cache_chk

bind twc_cache_top twc_cache_chk u_chk (.clk_sys_i, .rst_i, .bus_64bit_i, .ic_req_i, .ic_valid_o, .ic_busy_o,
    .dc_req_i, .dc_valid_o, .dc_hit_o, .dc_busy_o, .fill_req_o, .fill_pa_o, .fill_way_select_o, .fill_beat_i,
    .snoop_valid_i, .snoop_pa_i, .snoop_hit_o);

// *** test/twc_cache_top_tb_top.sv ***
// self-checking bench for the two-way cache pair
`timescale 1ns/1ps
module twc_cache_top_tb_top;
    import twc_pkg::*;
    localparam twc_word_t EA5 = 32'h0abc_d0a0;
    localparam twc_tag_t  TA  = 20'h11111;
    localparam twc_tag_t  TB  = 20'h22222;
    localparam twc_tag_t  TC  = 20'h33333;
    logic      clk_sys_i, rst_i, bus_64bit_i, slow;
    logic      ic_req_i, ic_valid_o, ic_hit_o, ic_busy_o;
    logic      dc_req_i, dc_valid_o, dc_hit_o, dc_busy_o;
    logic      fill_req_o, fill_way_select_o, fill_is_data_o, fill_beat_i;
    logic      snoop_valid_i, snoop_hit_o;
    twc_word_t ic_ea_i, ic_word_o, dc_ea_i, dc_word_o, fill_pa_o, snoop_pa_i;
    twc_tag_t  ic_pa_tag_i, dc_pa_tag_i;
    twc_byte_t ic_byte_o, dc_byte_o;
    twc_beat_t fill_data_i;
    int        miscompares = 0;
    int        n_compared = 0;

    twc_cache_top dut (.clk_sys_i, .rst_i, .bus_64bit_i, .ic_req_i, .ic_ea_i, .ic_pa_tag_i, .ic_valid_o,
        .ic_hit_o, .ic_word_o, .ic_byte_o, .ic_busy_o, .dc_req_i, .dc_ea_i, .dc_pa_tag_i, .dc_valid_o,
        .dc_hit_o, .dc_word_o, .dc_byte_o, .dc_busy_o, .fill_req_o, .fill_pa_o, .fill_way_select_o,
        .fill_is_data_o, .fill_beat_i, .fill_data_i, .snoop_valid_i, .snoop_pa_i, .snoop_hit_o);

    twc_fill_mem u_mem (.clk_sys_i(clk_sys_i), .fill_req_i(fill_req_o), .fill_pa_i(fill_pa_o),
        .bus64_i(bus_64bit_i), .slow_i(slow), .beat_o(fill_beat_i), .data_o(fill_data_i));

    initial begin
        clk_sys_i = 1'b0;
        forever #50 clk_sys_i = ~clk_sys_i;
    end

    function automatic twc_word_t exp_word(input twc_word_t pa, input logic [2:0] wi);
        exp_word = {pa[31:5], wi, 2'h0} ^ 32'h3c3c_0000;
    endfunction : exp_word

    task automatic tick();
        @(posedge clk_sys_i);
        #1;
    endtask : tick

    task automatic chk1(input logic got, input logic exp, input string m);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask : chk1

    task automatic chkw(input twc_word_t got, input twc_word_t exp, input string m);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask : chkw

    // leaves the request up so hits can follow back to back
    task automatic look(input logic d, input twc_word_t ea, input twc_tag_t tg, input logic hit);
        twc_word_t w;
        if (d) begin
            dc_req_i = 1'b1;
            dc_ea_i = ea;
            dc_pa_tag_i = tg;
        end else begin
            ic_req_i = 1'b1;
            ic_ea_i = ea;
            ic_pa_tag_i = tg;
        end
        tick();
        w = exp_word({tg, ea[11:5], 5'h00}, ea[4:2]);
        chk1(d ? dc_valid_o : ic_valid_o, 1'b1, "lookup answer");
        chk1(d ? dc_hit_o : ic_hit_o, hit, "hit flag");
        if (hit) begin
            chkw(d ? dc_word_o : ic_word_o, w, "word");
            chkw({24'h0, d ? dc_byte_o : ic_byte_o}, {24'h0, w[(3 - ea[1:0]) * 8 +: 8]}, "byte");
        end
    endtask : look

    task automatic rel();
        ic_req_i = 1'b0;
        dc_req_i = 1'b0;
        tick();
    endtask : rel

    task automatic words(input logic d, input twc_word_t ea, input twc_tag_t tg);
        for (int w = 0; w < 8; w++) look(d, ea | twc_word_t'(w * 4 + w % 4), tg, 1'b1);
        rel();
    endtask : words

    task automatic miss(input logic d, input twc_word_t ea, input twc_tag_t tg, input logic way);
        int n;
        look(d, ea, tg, 1'b0);
        ic_req_i = 1'b0;
        dc_req_i = 1'b0;
        for (n = 0; n < 50 && fill_req_o !== 1'b1; n++) tick();
        chk1(fill_req_o, 1'b1, "fill start");
        chk1(fill_way_select_o, way, "fill way");
        chkw(fill_pa_o, {tg, ea[11:5], 5'h00}, "fill address");
        chk1(fill_is_data_o, d, "fill cache");
        for (n = 0; n < 50 && (d ? dc_busy_o : ic_busy_o) === 1'b1; n++) tick();
        chk1(fill_req_o, 1'b0, "fill end");
    endtask : miss

    task automatic lru_order();
        miss(1'b1, EA5, TA, WAY0);
        words(1'b1, EA5, TA);
        miss(1'b1, EA5 ^ 32'h20, TA, WAY0);
        miss(1'b1, EA5, TB, WAY1);
        look(1'b1, EA5, TA, 1'b1);
        rel();
        miss(1'b1, EA5, TC, WAY1);
        look(1'b1, EA5, TA, 1'b1);
        look(1'b1, EA5, TC, 1'b1);
        rel();
    endtask : lru_order

    // an absent line first, then the resident one, matched by physical tag
    task automatic snoop_resident();
        for (int i = 0; i < 2; i++) begin
            snoop_valid_i = 1'b1;
            snoop_pa_i = {i ? TC : 20'h44444, 7'd5, 5'h00};
            tick();
            chk1(snoop_hit_o, i[0], "resident snoop");
            snoop_valid_i = 1'b0;
            tick();
        end
        miss(1'b1, EA5, TC, WAY0);
    endtask : snoop_resident

    task automatic snoop_fill(input logic b64, input twc_word_t ea, input twc_tag_t tg);
        int   nb;
        logic e;
        logic s;
        bus_64bit_i = b64;
        slow = 1'b1;
        repeat (4) tick();
        look(1'b1, ea, tg, 1'b0);
        dc_req_i = 1'b0;
        nb = 0;
        for (int n = 0; n < 60 && dc_busy_o === 1'b1; n++) begin
            snoop_pa_i = {tg, ea[11:5], 5'h00};
            snoop_valid_i = fill_req_o && !fill_beat_i;
            s = snoop_valid_i;
            e = b64 ? nb != 3 : nb < 6;
            nb += int'(fill_req_o && fill_beat_i);
            tick();
            if (s) chk1(snoop_hit_o, e, "fill line snoop");
        end
        snoop_valid_i = 1'b0;
        chk1(nb == (b64 ? 4 : 8), 1'b1, "beats per line");
        words(1'b1, ea, tg);
    endtask : snoop_fill

    task automatic ic_32bit();
        slow = 1'b0;
        miss(1'b0, 32'h0abc_dfe0, 20'h77777, WAY0);
        words(1'b0, 32'h0abc_dfe0, 20'h77777);
    endtask : ic_32bit

    task automatic conclude();
        $display("compared %0d, miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : conclude

    // the whole sequence needs well under a thousand cycles
    initial begin
        #1_000_000;
        miscompares++;
        conclude();
    end

    initial begin
        rst_i = 1'b1;
        bus_64bit_i = 1'b1;
        slow = 1'b0;
        ic_req_i = 1'b0;
        dc_req_i = 1'b0;
        ic_ea_i = '0;
        dc_ea_i = '0;
        ic_pa_tag_i = '0;
        dc_pa_tag_i = '0;
        snoop_valid_i = 1'b0;
        snoop_pa_i = '0;
        repeat (5) @(posedge clk_sys_i);
        #1;
        rst_i = 1'b0;
        lru_order();
        snoop_resident();
        snoop_fill(1'b1, 32'h0abc_d120, 20'h55555);
        snoop_fill(1'b0, 32'h0abc_d140, 20'h66666);
        ic_32bit();
        conclude();
    end
endmodule : twc_cache_top_tb_top

// *** test/twc_fill_mem.sv ***
// line-fill responder standing in for the system bus
`timescale 1ns/1ps
module twc_fill_mem
(
    input  wire logic               clk_sys_i,
    input  wire logic               fill_req_i,
    input  wire twc_pkg::twc_word_t fill_pa_i,
    input  wire logic               bus64_i,
    input  wire logic               slow_i,
    output logic                    beat_o,
    output twc_pkg::twc_beat_t      data_o
);
    import twc_pkg::*;
    twc_cnt_t cnt_q;
    twc_cnt_t nxt;

    function automatic twc_word_t pat(input twc_word_t pa, input int w);
        pat = {pa[31:5], w[2:0], 2'h0} ^ 32'h3c3c_0000;
    endfunction : pat

    initial begin
        beat_o = 1'b0;
        data_o = '0;
        cnt_q  = BEAT_ZERO;
    end

    // slow mode leaves a gap after every beat
    always @(posedge clk_sys_i) begin
        nxt = cnt_q + {3'h0, fill_req_i && beat_o};
        cnt_q <= fill_req_i ? nxt : BEAT_ZERO;
        if (fill_req_i && nxt < (bus64_i ? BEATS_64 : BEATS_32) && !(slow_i && beat_o)) begin
            beat_o <= 1'b1;
            data_o <= bus64_i ? {pat(fill_pa_i, 2 * nxt), pat(fill_pa_i, 2 * nxt + 1)}
                              : {pat(fill_pa_i, nxt), ~pat(fill_pa_i, nxt)};
        end else begin
            beat_o <= 1'b0;
            data_o <= ~data_o; // idle lanes alternate between the last beat and its complement
        end
    end
endmodule : twc_fill_mem
